// ===== design/qst_pkg.sv
package qst_pkg;
  // Register byte offsets on the bus
  typedef logic [4:0] qst_addr_t;
  localparam qst_addr_t OFS_CTRL  = 5'h00;
  localparam qst_addr_t OFS_STAT  = 5'h04;
  localparam qst_addr_t OFS_MATCH = 5'h08;
  localparam qst_addr_t OFS_COUNT = 5'h0c;
  localparam qst_addr_t OFS_GATE  = 5'h10;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       en;       // Module enable, bit 7
    logic [1:0] src;      // Reference source select, bits 6:5
    logic       clr;      // Count clear, bit 4, reads zero
    logic       tick_oe;  // Tick output enable, bit 3
    logic [2:0] ps;       // Prescale select, bits 2:0
  } qst_ctrl_s;

  // Status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic qsec_f;    // Quarter event flag
    logic sec_f;     // Second event flag
    logic match_f;   // Match event flag
    logic qsec_ie;   // Quarter interrupt enable
    logic sec_ie;    // Second interrupt enable
    logic match_ie;  // Match interrupt enable
    logic match_en;  // Match function enable
    logic mwc;       // Match write pending
  } qst_stat_s;

  // Values after reset, and the count low bits of a second event
  localparam logic [7:0] CTRL_RESET  = 8'h01;
  localparam logic [7:0] STAT_RESET  = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic       GATE_RESET  = 1'b1;
  localparam logic [1:0] QTR_MASK    = 2'h0;

  // Reference source codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_LPO = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;

  // Division counts per prescale code: reference to tick, tick to 4 Hz
  localparam int PRE_W  = 9;
  localparam int MAIN_W = 14;
  localparam logic [PRE_W-1:0] PRE_DIV [8] =
    '{9'h001, 9'h001, 9'h001, 9'h001, 9'h080, 9'h07d, 9'h0fa, 9'h1f4};
  localparam logic [MAIN_W-1:0] MAIN_DIV [8] =
    '{14'h00fa, 14'h2000, 14'h1f40, 14'h2580,
      14'h2580, 14'h1f40, 14'h1f40, 14'h1f40};
endpackage

// ===== design/qst_timekeeper.sv
`timescale 1ns/1ps
// Behaviour
// RL1 - 8-bit count advances each quarter second
// RL2 - 6-bit match value, one shared interrupt
// RL3 - Bits 6:5 choose reference clock source
// RL4 - Software keeps source fixed while enabled
// RL5 - Disabled: count and divider held cleared
// RL6 - Writing one clears count and divider
// RL7 - Bit 3 gates tick output, runs low-power
// RL8 - Prescale codes 000-011 for low rates
// RL9 - Codes 100-111 for megahertz inputs
// RL10 - Tick output equals intermediate frequency
// RL11 - Software keeps prescale fixed while enabled
// RL12 - Self-clearing match pulse, ignores irq enable
// RL13 - Any event wakes from low-power modes; code wakes only when the shared interrupt is raised
// RL14 - Internal reference unusable in deep stop
// RL15 - Registers keep contents across deep stop
// RL16 - Gate bit, set at reset, cuts access
// RL17 - Second event every fourth count
// RL18 - Match sets flag, clears upper six bits
// RL19 - Flags clear only by writing one
// RL20 - Interrupt when enabled flag set, module on
module qst_timekeeper
(
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_N,
  input  wire qst_pkg::qst_addr_t  I_ADDRESS,
  input  wire logic                I_READ,
  input  wire logic                I_WRITE,
  input  wire logic [3:0]          I_BYTEENABLE,
  input  wire logic [31:0]         I_WRITEDATA,
  output logic [31:0]              O_READDATA,
  output logic                     O_WAITREQUEST,
  input  wire logic                I_EXT_OSC_CLOCK,
  input  wire logic                I_LOW_POWER_OSC,
  input  wire logic                I_INTERNAL_REF_CLOCK,
  input  wire logic                I_DEEP_STOP,
  input  wire logic                I_LOW_POWER_MODE,
  output logic                     O_IRQ,
  output logic                     O_WAKE,
  output logic                     O_MATCH_PULSE_OUT,
  output logic                     O_TICK_CLOCK_OUT
);
  import qst_pkg::*;

  // Three-stage synchronisers for the reference pins
  logic [2:0] sync1;       // First stage, read only by sync2
  logic [2:0] sync2;       // Second stage
  logic [2:0] sync3;       // Third stage
  logic [2:0] filt;        // Level accepted when stages two and three agree
  logic [2:0] filt_d;      // Delayed accepted level
  logic [2:0] next_filt;   // Next accepted level

  // Accepted level follows only agreeing stages
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
    end
  end

  // Synchroniser registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sync1  <= 3'h0;
      sync2  <= 3'h0;
      sync3  <= 3'h0;
      filt   <= 3'h0;
      filt_d <= 3'h0;
    end
    else
    begin
      sync1  <= {I_INTERNAL_REF_CLOCK, I_LOW_POWER_OSC, I_EXT_OSC_CLOCK};
      sync2  <= sync1;
      sync3  <= sync2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  // Rising edges of each reference, index by source code
  logic [2:0] ref_rise;
  assign ref_rise = filt & ~filt_d;

  // Block state
  qst_ctrl_s          ctrl;        // Control register, clr always zero
  qst_stat_s          stat;        // Status and enable register
  logic [5:0]         match_val;   // Match value
  logic [1:0]         match_qtr;   // Count low bits captured on match write
  logic [7:0]         count;       // Quarter count
  logic               gate;        // Bus clock gate bit
  logic [PRE_W-1:0]   pre_cnt;     // Reference to tick divider
  logic [MAIN_W-1:0]  main_cnt;    // Tick to 4 Hz divider
  logic               wait_q;      // Waitrequest register
  logic [31:0]        rdata;       // Read data register
  logic               irq;         // Interrupt register
  logic               wake;        // Wake register
  logic               mpulse;      // Match pulse register
  logic               tick_out;    // Tick output register

  // Next values
  qst_ctrl_s          next_ctrl;
  qst_stat_s          next_stat;
  logic [5:0]         next_match_val;
  logic [1:0]         next_match_qtr;
  logic [7:0]         next_count;
  logic               next_gate;
  logic [PRE_W-1:0]   next_pre_cnt;
  logic [MAIN_W-1:0]  next_main_cnt;
  logic               next_wait_q;
  logic [31:0]        next_rdata;
  logic               next_irq;
  logic               next_wake;
  logic               next_mpulse;
  logic               next_tick_out;

  // Scratch terms of the main process
  logic               ref_tick;    // Selected reference edge
  logic               mid_tick;    // Intermediate frequency tick
  logic               qtr_tick;    // 4 Hz tick
  logic [7:0]         inc;         // Incremented count
  logic               bus_wr;      // Write accepted this edge
  logic               bus_rd;      // Read answered this edge
  logic               reg_ok;      // Clock gate open
  logic               do_clr;      // Count clear requested
  logic [7:0]         wbyte;       // Low write byte
  logic               set_q;       // Quarter event
  logic               set_s;       // Second event
  logic               set_m;       // Match event
  logic [2:0]         w1c;         // Flag clear strobes

  // Dividers, count, flags, bus slave
  always_comb
  begin
    next_ctrl      = ctrl;
    next_stat      = stat;
    next_match_val = match_val;
    next_match_qtr = match_qtr;
    next_count     = count;
    next_gate      = gate;
    next_pre_cnt   = pre_cnt;
    next_main_cnt  = main_cnt;
    next_rdata     = rdata;
    next_mpulse    = 1'b0;
    set_q          = 1'b0;
    set_s          = 1'b0;
    set_m          = 1'b0;
    mid_tick       = 1'b0;
    qtr_tick       = 1'b0;
    w1c            = 3'h0;
    inc            = count + 8'h01;
    wbyte          = I_WRITEDATA[7:0];

    // Waitrequest drops one cycle after a request, for one cycle
    next_wait_q = !((I_READ || I_WRITE) && wait_q);
    bus_wr = I_WRITE && !wait_q && I_BYTEENABLE[0];
    bus_rd = I_READ && wait_q;   // Loaded as wait drops, stands at answer
    reg_ok = gate;

    // Source select; internal reference absent in deep stop
    unique case (ctrl.src) // RL3
      SRC_EXT: ref_tick = ref_rise[0];
      SRC_LPO: ref_tick = ref_rise[1];
      SRC_INT: ref_tick = ref_rise[2] && !I_DEEP_STOP; // RL14
      default: ref_tick = 1'b0;
    endcase

    // Two-stage prescaler: reference to tick, tick to 4 Hz
    if (ref_tick)
    begin
      if (pre_cnt >= PRE_DIV[ctrl.ps] - 9'h001) // RL8 RL9
      begin
        next_pre_cnt = '0;
        mid_tick     = 1'b1;
      end
      else
      begin
        next_pre_cnt = pre_cnt + 9'h001;
      end
    end
    if (mid_tick)
    begin
      if (main_cnt >= MAIN_DIV[ctrl.ps] - 14'h0001) // RL8 RL9
      begin
        next_main_cnt = '0;
        qtr_tick      = 1'b1;
      end
      else
      begin
        next_main_cnt = main_cnt + 14'h0001;
      end
    end

    // Quarter count advance with second and match events
    if (qtr_tick)
    begin
      next_count = inc; // RL1
      set_q      = 1'b1; // RL17
      set_s      = (inc[1:0] == QTR_MASK); // RL17
      if (stat.match_en && inc[7:2] == match_val) // RL18
      begin
        set_m       = 1'b1;
        next_mpulse = 1'b1; // RL12
        next_count  = {6'h00, inc[1:0]}; // RL18
      end
    end

    // Match write indication lasts one cycle
    next_stat.mwc = 1'b0;

    // Register writes; only the gate is reachable while gated
    if (bus_wr)
    begin
      if (I_ADDRESS == OFS_GATE)
      begin
        next_gate = wbyte[0]; // RL16
      end
      else if (reg_ok)
      begin
        unique case (I_ADDRESS)
          OFS_CTRL:
          begin
            next_ctrl     = qst_ctrl_s'(wbyte);
            next_ctrl.clr = 1'b0; // RL6
          end
          OFS_STAT:
          begin
            w1c                = wbyte[7:5]; // RL19
            next_stat.qsec_ie  = wbyte[4];
            next_stat.sec_ie   = wbyte[3];
            next_stat.match_ie = wbyte[2];
            next_stat.match_en = wbyte[1];
          end
          OFS_MATCH:
          begin
            next_match_val = wbyte[7:2]; // RL2
            next_match_qtr = count[1:0];
            next_stat.mwc  = 1'b1;
          end
          default:
          begin
            next_gate = gate;  // Unmapped or read-only: ignored
          end
        endcase
      end
    end
    do_clr = bus_wr && reg_ok && I_ADDRESS == OFS_CTRL && wbyte[4];

    // Flags: a set wins over a clear in the same cycle
    next_stat.qsec_f  = (stat.qsec_f && !w1c[2]) || set_q; // RL19
    next_stat.sec_f   = (stat.sec_f && !w1c[1]) || set_s; // RL19
    next_stat.match_f = (stat.match_f && !w1c[0]) || set_m; // RL19

    // Disabled or cleared: count and dividers go to zero
    if (!ctrl.en || do_clr) // RL5 RL6
    begin
      next_count    = COUNT_RESET;
      next_pre_cnt  = '0;
      next_main_cnt = '0;
      next_mpulse   = 1'b0;
    end

    // Read data, zero when gated or unmapped
    if (bus_rd)
    begin
      next_rdata = 32'h0;
      if (I_ADDRESS == OFS_GATE)
      begin
        next_rdata[0] = gate;
      end
      else if (reg_ok)
      begin
        unique case (I_ADDRESS)
          OFS_CTRL:  next_rdata[7:0] = ctrl;
          OFS_STAT:  next_rdata[7:0] = stat;
          OFS_MATCH: next_rdata[7:0] = {match_val, match_qtr};
          OFS_COUNT: next_rdata[7:0] = count;
          default:   next_rdata      = 32'h0;
        endcase
      end
    end

    // Shared interrupt, wake request and tick output
    next_irq = ctrl.en && ((stat.qsec_f && stat.qsec_ie) ||
                           (stat.sec_f && stat.sec_ie) ||
                           (stat.match_f && stat.match_ie)); // RL2 RL20
    next_wake     = next_irq && I_LOW_POWER_MODE; // RL13
    next_tick_out = mid_tick && ctrl.en && ctrl.tick_oe; // RL7 RL10
  end

  // Main registers; no stop-mode reset, contents kept
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) // RL15
  begin
    if (!I_RST_N)
    begin
      ctrl      <= qst_ctrl_s'(CTRL_RESET);
      stat      <= qst_stat_s'(STAT_RESET);
      match_val <= MATCH_RESET[7:2];
      match_qtr <= MATCH_RESET[1:0];
      count     <= COUNT_RESET;
      gate      <= GATE_RESET; // RL16
      pre_cnt   <= '0;
      main_cnt  <= '0;
      wait_q    <= 1'b1;
      rdata     <= 32'h0;
      irq       <= 1'b0;
      wake      <= 1'b0;
      mpulse    <= 1'b0;
      tick_out  <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      stat      <= next_stat;
      match_val <= next_match_val;
      match_qtr <= next_match_qtr;
      count     <= next_count;
      gate      <= next_gate;
      pre_cnt   <= next_pre_cnt;
      main_cnt  <= next_main_cnt;
      wait_q    <= next_wait_q;
      rdata     <= next_rdata;
      irq       <= next_irq;
      wake      <= next_wake;
      mpulse    <= next_mpulse;
      tick_out  <= next_tick_out;
    end
  end

  // Outputs straight from registers
  assign O_READDATA        = rdata;
  assign O_WAITREQUEST     = wait_q;
  assign O_IRQ             = irq;
  assign O_WAKE            = wake;
  assign O_MATCH_PULSE_OUT = mpulse;
  assign O_TICK_CLOCK_OUT  = tick_out;
endmodule

// ===== verification/qst_timekeeper_props.sv
`timescale 1ns/1ps
// Port-level checks for the timekeeper
module qst_timekeeper_props
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_READ,
  input wire logic        I_WRITE,
  input wire logic        I_LOW_POWER_MODE,
  input wire logic [31:0] O_READDATA,
  input wire logic        O_WAITREQUEST,
  input wire logic        O_IRQ,
  input wire logic        O_WAKE,
  input wire logic        O_MATCH_PULSE_OUT,
  input wire logic        O_TICK_CLOCK_OUT
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  // Request still waiting for its answer
  sequence bus_req;
    (I_READ || I_WRITE) && O_WAITREQUEST;
  endsequence
  // Answer cycle
  sequence bus_ack;
    !O_WAITREQUEST;
  endsequence
  wait_one_a: assert property (bus_req |=> bus_ack)
    else $error("Bus answer late");
  ack_short_a: assert property (bus_ack |=> O_WAITREQUEST)
    else $error("Bus answer too long");
  idle_wait_a: assert property
    (!I_READ && !I_WRITE && O_WAITREQUEST |=> O_WAITREQUEST)
    else $error("Answer without request");
  rdata_hold_a: assert property (!$stable(O_READDATA) |-> bus_ack)
    else $error("Read data moved outside an answer");
  upper_zero_a: assert property
    (bus_ack |-> O_READDATA[31:8] == 24'h0)
    else $error("Read data upper lanes not zero");
  pulse_once_a: assert property
    (O_MATCH_PULSE_OUT |=> !O_MATCH_PULSE_OUT [*8])
    else $error("Match pulse not self-clearing");
  tick_once_a: assert property (O_TICK_CLOCK_OUT |=> !O_TICK_CLOCK_OUT)
    else $error("Tick pulse too long");
  wake_irq_a: assert property
    (O_WAKE == (O_IRQ && $past(I_LOW_POWER_MODE)))
    else $error("Wake does not follow request");
endmodule

bind qst_timekeeper qst_timekeeper_props i_qst_timekeeper_props
  (.I_REF_CLK, .I_RST_N, .I_READ, .I_WRITE, .I_LOW_POWER_MODE,
   .O_READDATA, .O_WAITREQUEST, .O_IRQ, .O_WAKE, .O_MATCH_PULSE_OUT,
   .O_TICK_CLOCK_OUT);

// ===== verification/tb_qst_timekeeper.sv
`timescale 1ns/1ps
// Self-checking bench for the timekeeper
module tb_qst_timekeeper;
  import qst_pkg::*;
  logic        ref_clk = 1'b0;  // System clock
  logic        rst_n   = 1'b0;  // Reset, active low
  qst_addr_t   addr    = '0;    // Bus address
  logic        rd_en   = 1'b0;  // Bus read
  logic        wr_en   = 1'b0;  // Bus write
  logic [31:0] wdata   = '0;    // Bus write data
  logic [31:0] rdata;           // Bus read data
  logic        waitreq;         // Bus wait
  logic [2:0]  refs    = '0;    // External, low-power, internal sources
  logic        deep    = 1'b0;  // Deepest stop
  logic        lpm     = 1'b0;  // Any low-power mode
  logic        irq;             // Shared request
  logic        wake;            // Wake request
  logic        mpulse;          // Match pulse
  logic        tick;            // Tick pulse
  logic [31:0] seed    = 32'h779b; // Random state
  int          mismatches  = 0;
  int          comparisons = 0;
  int          ticks  = 0;      // Tick pulses seen
  int          pulses = 0;      // Match pulses seen
  int          m;               // Random match value

  always #5 ref_clk = ~ref_clk;

  qst_timekeeper i_qst_timekeeper (.I_REF_CLK(ref_clk), .I_RST_N(rst_n),
    .I_ADDRESS(addr), .I_READ(rd_en), .I_WRITE(wr_en),
    .I_BYTEENABLE(4'hf), .I_WRITEDATA(wdata), .O_READDATA(rdata),
    .O_WAITREQUEST(waitreq), .I_EXT_OSC_CLOCK(refs[0]),
    .I_LOW_POWER_OSC(refs[1]), .I_INTERNAL_REF_CLOCK(refs[2]),
    .I_DEEP_STOP(deep), .I_LOW_POWER_MODE(lpm), .O_IRQ(irq),
    .O_WAKE(wake), .O_MATCH_PULSE_OUT(mpulse), .O_TICK_CLOCK_OUT(tick));

  // Counts output pulses
  always @(posedge ref_clk)
  begin
    if (tick === 1'b1) ticks++;
    if (mpulse === 1'b1) pulses++;
  end

  // Xorshift step
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input qst_addr_t a,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    addr  <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wdata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0)
    begin
      mismatches++;
      $display("MISMATCH %0t bus timeout", $time);
      complete_run();
    end
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic wr(input qst_addr_t a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input qst_addr_t a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  // Rising edges on one source, random high time
  task automatic edges(input int n, input int w);
    repeat (n)
    begin
      refs[w] <= 1'b1;
      repeat (2 + xs() % 3) @(posedge ref_clk);
      refs[w] <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (8) @(posedge ref_clk);
  endtask

  // Main sequence
  initial
  begin
    int t0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_STAT, STAT_RESET);
    rd(OFS_MATCH, MATCH_RESET);
    rd(OFS_COUNT, COUNT_RESET);
    rd(OFS_GATE, {7'h0, GATE_RESET});
    wr(5'h14, 8'hff);
    rd(5'h14, 8'h00);
    wr(OFS_CTRL, 8'h28);
    wr(OFS_CTRL, 8'ha8);
    rd(OFS_CTRL, 8'ha8);
    t0 = ticks;
    edges(500, 0);
    rd(OFS_COUNT, 8'h00);
    edges(500, 1);
    rd(OFS_COUNT, 8'h02);
    chk(ticks - t0, 500);
    rd(OFS_STAT, 8'h80);
    wr(OFS_STAT, 8'h00);
    rd(OFS_STAT, 8'h80);
    edges(500, 1);
    rd(OFS_STAT, 8'hc0);
    wr(OFS_STAT, 8'h10);
    lpm <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(irq, 32'h1);
    chk(wake, 32'h1);
    wr(OFS_STAT, 8'hd0);
    rd(OFS_STAT, 8'h10);
    chk(irq, 32'h0);
    lpm <= 1'b0;
    // Partial divider, then clear restarts from zero
    edges(100, 1);
    wr(OFS_CTRL, 8'hb8);
    rd(OFS_CTRL, 8'ha8);
    edges(150, 1);
    rd(OFS_COUNT, 8'h00);
    m = 1 + xs() % 2;
    wr(OFS_MATCH, 8'(m << 2));
    wr(OFS_STAT, 8'h02);
    rd(OFS_MATCH, 8'(m << 2));
    t0 = pulses;
    edges(1000 * m - 150, 1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_STAT, 8'he2);
    chk(pulses - t0, 1);
    // Four megahertz prescale: one tick per 125 reference edges
    wr(OFS_CTRL, 8'h2d);
    wr(OFS_CTRL, 8'had);
    t0 = ticks;
    edges(250, 1);
    chk(ticks - t0, 2);
    rd(OFS_COUNT, 8'h00);
    // Internal source in deepest stop, tick output off
    wr(OFS_CTRL, 8'h20);
    wr(OFS_CTRL, 8'h40);
    wr(OFS_CTRL, 8'hc0);
    deep <= 1'b1;
    t0 = ticks;
    edges(250, 2);
    rd(OFS_COUNT, 8'h00);
    deep <= 1'b0;
    edges(250, 2);
    rd(OFS_COUNT, 8'h01);
    chk(ticks - t0, 0);
    wr(OFS_CTRL, 8'h40);
    rd(OFS_COUNT, 8'h00);
    wr(OFS_GATE, 8'h00);
    rd(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h1f);
    wr(OFS_GATE, 8'h01);
    rd(OFS_CTRL, 8'h40);
    complete_run();
  end
endmodule
